//--- hdl/cmsb_buffer.sv
// one 16-byte message buffer: 13-byte structure plus local priority
`timescale 1ns/100ps
module cmsb_buffer (
	input wire logic clk,
	input wire logic cpu_we,
	input wire logic [3:0] cpu_idx,
	input wire logic [7:0] cpu_wdata,
	input wire logic load_en,
	input wire cmsb_pkg::cmsb_frame_s load_frame,
	input wire logic [3:0] rd_idx,
	output logic [7:0] rd_data,
	output cmsb_pkg::cmsb_frame_s frame,
	output logic [7:0] local_prio
);
	import cmsb_pkg::*;

	logic [7:0] mem_q [CMSB_STRUCT_BYTES];
	logic [7:0] mem_d [CMSB_STRUCT_BYTES];
	logic [7:0] prio_q;
	logic [7:0] prio_d;

	// ============================================================
	// next contents
	always_comb begin
		mem_d = mem_q;
		prio_d = prio_q;
		if (load_en) begin
			for (int i = 0; i < CMSB_STRUCT_BYTES; i++) begin
				mem_d[i] = load_frame[8 * (CMSB_STRUCT_BYTES - 1 - i) +: 8];
			end
		end else if (cpu_we) begin
			if (cpu_idx < CMSB_IDX_PRIO) begin
				mem_d[cpu_idx] = cpu_wdata;
			end else if (cpu_idx == CMSB_IDX_PRIO) begin
				prio_d = cpu_wdata;
			end
		end
	end

	always_ff @(posedge clk) begin
		mem_q <= mem_d;
		prio_q <= prio_d;
	end

	// ============================================================
	// read views
	always_comb begin
		rd_data = 8'h00;
		if (rd_idx < CMSB_IDX_PRIO) begin
			rd_data = mem_q[rd_idx];
		end else if (rd_idx == CMSB_IDX_PRIO) begin
			rd_data = prio_q;
		end
		for (int i = 0; i < CMSB_STRUCT_BYTES; i++) begin
			frame[8 * (CMSB_STRUCT_BYTES - 1 - i) +: 8] = mem_q[i];
		end
	end

	assign local_prio = prio_q;

endmodule : cmsb_buffer

//--- hdl/cmsb_storage.sv
// message buffer storage and address decode of the CAN controller
// Overview of operation
// - decode one 128-byte region and answer accesses inside it only
// - background receive buffer visible to the cpu only in test mode
// - control, error counter, filter and port areas at fixed offsets, gaps reserved
// - receive buffer at 0140, transmit buffers at 0150, 0160, 0170
// - each buffer is 13-byte structure, priority byte (transmit buffers only), two unused bytes
// - buffer structure has no reset value
// - receive buffer read-only; transmit buffers read and write anytime
// - bytes 0-3 identifier, 4-B payload, C length, D priority
// - address bits 6:4 select buffer: 4 receive, 5-7 transmit
// - identifier bytes hold 11-bit or 29-bit identifiers
// - standard layout: id 10..3, then id 2..0, rtr, ide
// - extended layout: id, srr, ide, id bits, rtr in last bit
// - identifier msb goes out first during arbitration
// - smallest value means highest priority
// - software writes srr as one; received srr stored as seen
// - ide captured on receive, selects format on transmit
// - rtr captured on receive, sets sent rtr on transmit
// - length gives zero to eight bytes; remote frames carry none
`timescale 1ns/100ps
module cmsb_storage #(
	parameter int ADDR_W = cmsb_pkg::CMSB_ADDR_W,
	parameter logic [15:0] BASE_ADDR = cmsb_pkg::CMSB_BASE_ADDR
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic test_mode,
	input wire logic [ADDR_W-1:0] cpu_addr,
	input wire logic cpu_rd,
	input wire logic cpu_wr,
	input wire logic [7:0] cpu_wdata,
	output logic [7:0] cpu_rdata,
	output logic cpu_hit,
	output cmsb_pkg::cmsb_area_e cpu_area,
	input wire logic rx_store,
	input wire cmsb_pkg::cmsb_rx_s rx_frame,
	input wire logic rx_copy,
	input wire logic [2:0] tx_request,
	input wire logic tx_arbitrate,
	output logic tx_valid,
	output logic [1:0] tx_winner,
	output cmsb_pkg::cmsb_tx_s tx_frame
);
	import cmsb_pkg::*;

	// ============================================================
	// elaboration checks
	if (ADDR_W < 8 || ADDR_W > 16) begin : g_bad_width
		$error("address width must lie between 8 and 16");
	end
	if (BASE_ADDR[6:0] != 7'h00) begin : g_bad_base
		$error("base address must be aligned to the region size");
	end
	if (CMSB_REGION_BYTES != 128) begin : g_bad_region
		$error("region decode assumes 128 bytes");
	end
	if (CMSB_STRUCT_BYTES + 3 != CMSB_BUF_BYTES) begin : g_bad_layout
		$error("buffer must hold the structure, priority and two unused bytes");
	end
	if (CMSB_IDX_PRIO != 4'(CMSB_STRUCT_BYTES)) begin : g_bad_prio
		$error("priority byte must follow the structure");
	end
	if (CMSB_NUM_TX != 3) begin : g_bad_count
		$error("arbiter serves exactly three transmit buffers");
	end
	if (CMSB_SEL_RECEIVE_FOREGROUND_BUFFER != 3'h4 || CMSB_SEL_TX2 != 3'h7) begin : g_bad_select
		$error("buffer select decode assumes codes 4 to 7");
	end
	if (CMSB_BGVIEW_OFS <= CMSB_FILTER_LAST || CMSB_BGVIEW_LAST >= CMSB_PORT_OFS) begin : g_bad_view
		$error("background view must sit in the reserved gap");
	end
	if (CMSB_ID1_IDE != 3 || CMSB_ID1_RTR_STD != 4 || CMSB_ID1_SRR_EXT != 4) begin : g_bad_fields
		$error("identifier byte 1 field positions are fixed by the packing");
	end

	localparam int NUM_BUF = 5;
	localparam int BG_IDX = 4;

	logic in_region;
	logic [6:0] ofs;
	logic [3:0] byte_idx;
	logic is_buf;
	logic [1:0] buf_sel;
	logic bg_view;
	cmsb_area_e area;
	logic in_ctrl;
	logic in_errcnt;
	logic in_filter;
	logic in_port;
	logic cpu_access;
	logic buf_wr;
	logic [7:0] buf_rdata;
	logic arb_found;
	logic [7:0] arb_prio;
	logic [1:0] arb_best;
	logic [7:0] rd_w [NUM_BUF];
	cmsb_frame_s frame_w [NUM_BUF];
	logic [7:0] prio_w [NUM_BUF];
	logic we_w [NUM_BUF];
	logic load_w [NUM_BUF];
	cmsb_frame_s load_frame_w [NUM_BUF];
	cmsb_frame_s rx_packed;

	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic hit_q;
	logic hit_d;
	cmsb_area_e area_q;
	cmsb_area_e area_d;
	logic tx_valid_q;
	logic tx_valid_d;
	logic [1:0] tx_winner_q;
	logic [1:0] tx_winner_d;
	cmsb_tx_s tx_frame_q;
	cmsb_tx_s tx_frame_d;

	// ============================================================
	// region and area decode
	always_comb begin
		in_region = (cpu_addr[ADDR_W-1:7] == BASE_ADDR[ADDR_W-1:7]);
		ofs = cpu_addr[6:0];
		byte_idx = ofs[3:0];
		is_buf = (ofs[6:4] >= CMSB_SEL_RECEIVE_FOREGROUND_BUFFER);
		buf_sel = ofs[5:4];
		bg_view = test_mode && (ofs >= CMSB_BGVIEW_OFS) && (ofs <= CMSB_BGVIEW_LAST);
		in_ctrl = (ofs <= CMSB_CTRL_LAST);
		in_errcnt = (ofs >= CMSB_ERRCNT_OFS) && (ofs <= CMSB_ERRCNT_LAST);
		in_filter = (ofs >= CMSB_FILTER_OFS) && (ofs <= CMSB_FILTER_LAST);
		in_port = (ofs >= CMSB_PORT_OFS) && (ofs <= CMSB_PORT_LAST);
		if (!in_region) begin
			area = CMSB_AREA_NONE;
		end else if (is_buf) begin
			area = CMSB_AREA_BUFFER;
		end else if (in_ctrl) begin
			area = CMSB_AREA_CONTROL;
		end else if (in_errcnt) begin
			area = CMSB_AREA_ERRCNT;
		end else if (in_filter) begin
			area = CMSB_AREA_FILTER;
		end else if (in_port) begin
			area = CMSB_AREA_PORT;
		end else begin
			area = CMSB_AREA_RESERVED;
		end
	end

	// ============================================================
	// packing of received frames into identifier bytes
	always_comb begin
		rx_packed.payload = rx_frame.payload;
		rx_packed.length = {4'h0, rx_frame.dlc};
		if (rx_frame.ide) begin
			rx_packed.ident[31:24] = rx_frame.id[28:21];
			rx_packed.ident[23:16] = {rx_frame.id[20:18], rx_frame.srr, 1'b1, rx_frame.id[17:15]};
			rx_packed.ident[15:8] = rx_frame.id[14:7];
			rx_packed.ident[7:0] = {rx_frame.id[6:0], rx_frame.rtr};
		end else begin
			rx_packed.ident[31:24] = rx_frame.id[10:3];
			rx_packed.ident[23:16] = {rx_frame.id[2:0], rx_frame.rtr, 1'b0, 3'h0};
			rx_packed.ident[15:0] = 16'h0000;
		end
	end

	// ============================================================
	// buffers: 0 receive foreground, 1..3 transmit, 4 background
	always_comb begin
		for (int b = 0; b < NUM_BUF; b++) begin
			we_w[b] = 1'b0;
			load_w[b] = 1'b0;
			load_frame_w[b] = rx_packed;
		end
		buf_wr = cpu_wr && in_region && is_buf;
		// transmit buffers writable, receive buffer not
		for (int b = 1; b < 4; b++) begin
			we_w[b] = buf_wr && (buf_sel == 2'(b));
		end
		load_w[0] = rx_copy;
		load_frame_w[0] = frame_w[BG_IDX];
		load_w[BG_IDX] = rx_store;
	end

	for (genvar g = 0; g < NUM_BUF; g++) begin : g_buf
		cmsb_buffer u_buf (
			.clk(clk),
			.cpu_we(we_w[g]),
			.cpu_idx(byte_idx),
			.cpu_wdata(cpu_wdata),
			.load_en(load_w[g]),
			.load_frame(load_frame_w[g]),
			.rd_idx(byte_idx),
			.rd_data(rd_w[g]),
			.frame(frame_w[g]),
			.local_prio(prio_w[g])
		);
	end

	// receive buffer has no priority byte
	always_comb begin
		buf_rdata = rd_w[buf_sel];
		if (buf_sel == 2'd0 && byte_idx == CMSB_IDX_PRIO) begin
			buf_rdata = 8'h00;
		end
	end

	// ============================================================
	// cpu read path
	always_comb begin
		rdata_d = rdata_q;
		if (cpu_rd && in_region) begin
			rdata_d = 8'h00;
			if (is_buf) begin
				rdata_d = buf_rdata;
			end else if (bg_view) begin
				rdata_d = rd_w[BG_IDX];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			rdata_q <= CMSB_RDATA_RESET;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// ============================================================
	// access status
	always_comb begin
		cpu_access = cpu_rd || cpu_wr;
		hit_d = cpu_access && in_region;
		area_d = cpu_access ? area : CMSB_AREA_NONE;
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			hit_q <= 1'b0;
			area_q <= CMSB_AREA_NONE;
		end else begin
			hit_q <= hit_d;
			area_q <= area_d;
		end
	end

	// ============================================================
	// identifier unpacking
	function automatic cmsb_tx_s cmsb_unpack(input cmsb_frame_s f);
		cmsb_tx_s t;
		t.payload = f.payload;
		t.dlc = f.length[3:0];
		t.ide = f.ident[16 + CMSB_ID1_IDE];
		if (t.ide) begin
			// msb of identifier in top bit
			t.ident[28:18] = f.ident[31:21];
			t.ident[17:15] = f.ident[18:16];
			t.ident[14:7] = f.ident[15:8];
			t.ident[6:0] = f.ident[7:1];
			t.srr = f.ident[16 + CMSB_ID1_SRR_EXT];
			t.rtr = f.ident[CMSB_ID3_RTR_EXT];
		end else begin
			t.ident[28:18] = f.ident[31:21];
			t.ident[17:0] = 18'h00000;
			t.srr = 1'b0;
			t.rtr = f.ident[16 + CMSB_ID1_RTR_STD];
		end
		if (t.rtr) begin
			t.byte_count = 4'h0;
		end else if (t.dlc > CMSB_MAX_BYTES) begin
			t.byte_count = CMSB_MAX_BYTES;
		end else begin
			t.byte_count = t.dlc;
		end
		return t;
	endfunction : cmsb_unpack

	// ============================================================
	// transmit arbitration
	// smallest priority wins, lowest index on ties
	always_comb begin
		arb_found = 1'b0;
		arb_prio = 8'hFF;
		arb_best = 2'd0;
		for (int t = 0; t < CMSB_NUM_TX; t++) begin
			if (tx_request[t] && (!arb_found || prio_w[t + 1] < arb_prio)) begin
				arb_found = 1'b1;
				arb_prio = prio_w[t + 1];
				arb_best = 2'(t);
			end
		end
	end

	always_comb begin
		tx_valid_d = tx_valid_q;
		tx_winner_d = tx_winner_q;
		tx_frame_d = tx_frame_q;
		if (tx_arbitrate) begin
			tx_valid_d = arb_found;
			tx_winner_d = arb_best;
			tx_frame_d = cmsb_unpack(frame_w[arb_best + 2'd1]);
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			tx_valid_q <= 1'b0;
			tx_winner_q <= 2'd0;
			tx_frame_q <= '0;
		end else begin
			tx_valid_q <= tx_valid_d;
			tx_winner_q <= tx_winner_d;
			tx_frame_q <= tx_frame_d;
		end
	end

	// ============================================================
	// outputs
	assign cpu_rdata = rdata_q;
	assign cpu_hit = hit_q;
	assign cpu_area = area_q;
	assign tx_valid = tx_valid_q;
	assign tx_winner = tx_winner_q;
	assign tx_frame = tx_frame_q;

endmodule : cmsb_storage

//--- inc/cmsb_pkg.sv
// constants and types shared by the message buffer storage block
package cmsb_pkg;

	// ============================================================
	// address map
	localparam int CMSB_ADDR_W = 16;
	localparam logic [15:0] CMSB_BASE_ADDR = 16'h0100;
	localparam int CMSB_REGION_BYTES = 128;
	localparam logic [6:0] CMSB_CTRL_OFS = 7'h00;
	localparam logic [6:0] CMSB_CTRL_LAST = 7'h08;
	localparam logic [6:0] CMSB_ERRCNT_OFS = 7'h0E;
	localparam logic [6:0] CMSB_ERRCNT_LAST = 7'h0F;
	localparam logic [6:0] CMSB_FILTER_OFS = 7'h10;
	localparam logic [6:0] CMSB_FILTER_LAST = 7'h1F;
	localparam logic [6:0] CMSB_BGVIEW_OFS = 7'h20;
	localparam logic [6:0] CMSB_BGVIEW_LAST = 7'h2F;
	localparam logic [6:0] CMSB_PORT_OFS = 7'h3D;
	localparam logic [6:0] CMSB_PORT_LAST = 7'h3F;

	// ============================================================
	// buffer selection nibble and buffer layout
	localparam logic [2:0] CMSB_SEL_RECEIVE_FOREGROUND_BUFFER = 3'h4;
	localparam logic [2:0] CMSB_SEL_TX0 = 3'h5;
	localparam logic [2:0] CMSB_SEL_TX1 = 3'h6;
	localparam logic [2:0] CMSB_SEL_TX2 = 3'h7;
	localparam int CMSB_NUM_TX = 3;
	localparam int CMSB_BUF_BYTES = 16;
	localparam int CMSB_STRUCT_BYTES = 13;
	localparam logic [3:0] CMSB_IDX_ID0 = 4'h0;
	localparam logic [3:0] CMSB_IDX_ID3 = 4'h3;
	localparam logic [3:0] CMSB_IDX_PAYLOAD0 = 4'h4;
	localparam logic [3:0] CMSB_IDX_LENGTH = 4'hC;
	localparam logic [3:0] CMSB_IDX_PRIO = 4'hD;

	// ============================================================
	// identifier field positions
	localparam int CMSB_ID1_RTR_STD = 4;
	localparam int CMSB_ID1_SRR_EXT = 4;
	localparam int CMSB_ID1_IDE = 3;
	localparam int CMSB_ID3_RTR_EXT = 0;
	localparam logic [3:0] CMSB_MAX_BYTES = 4'h8;
	localparam logic [7:0] CMSB_RDATA_RESET = 8'h00;

	typedef enum logic [2:0] {
		CMSB_AREA_NONE,
		CMSB_AREA_CONTROL,
		CMSB_AREA_RESERVED,
		CMSB_AREA_ERRCNT,
		CMSB_AREA_FILTER,
		CMSB_AREA_PORT,
		CMSB_AREA_BUFFER
	} cmsb_area_e;

	// stored image of a buffer: ident byte 0 in [31:24], payload byte 0 in [63:56]
	typedef struct packed {
		logic [31:0] ident;
		logic [63:0] payload;
		logic [7:0] length;
	} cmsb_frame_s;

	// frame as delivered by the receive engine
	typedef struct packed {
		logic ide;
		logic srr;
		logic rtr;
		logic [28:0] id;
		logic [3:0] dlc;
		logic [63:0] payload;
	} cmsb_rx_s;

	// frame handed to the transmit engine, identifier msb first in bit 28
	typedef struct packed {
		logic ide;
		logic srr;
		logic rtr;
		logic [28:0] ident;
		logic [3:0] dlc;
		logic [3:0] byte_count;
		logic [63:0] payload;
	} cmsb_tx_s;

endpackage : cmsb_pkg

//--- test/cmsb_storage_monitor.sv
// port assertions for the message buffer storage
`timescale 1ns/100ps
module cmsb_storage_monitor #(
	parameter int ADDR_W = 16
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic test_mode,
	input wire logic [ADDR_W-1:0] cpu_addr,
	input wire logic cpu_rd,
	input wire logic cpu_wr,
	input wire logic [7:0] cpu_rdata,
	input wire logic cpu_hit,
	input wire cmsb_pkg::cmsb_area_e cpu_area,
	input wire logic tx_valid,
	input wire cmsb_pkg::cmsb_tx_s tx_frame
);
	import cmsb_pkg::*;
	wire acc = cpu_rd | cpu_wr;
	wire inr = cpu_addr[ADDR_W-1:7] == CMSB_BASE_ADDR[ADDR_W-1:7];
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	// ============================================================
	// decode, read data and transmit frame
	property p_hit; cpu_hit == $past(acc & inr); endproperty
	a_hit: assert property (p_hit) else $error("hit does not match region");
	property p_hold; !(cpu_rd && inr) |=> $stable(cpu_rdata); endproperty
	a_hold: assert property (p_hold) else $error("read data moved without read");
	property p_bg; cpu_rd && inr && cpu_addr[6:4] == 3'h2 && !test_mode |=> cpu_rdata == 8'h00; endproperty
	a_bg: assert property (p_bg) else $error("background buffer visible");
	property p_ctrl; acc && inr && cpu_addr[6:0] < 7'h09 |=> cpu_area == CMSB_AREA_CONTROL; endproperty
	a_ctrl: assert property (p_ctrl) else $error("control area misdecoded");
	property p_buf; acc && inr && cpu_addr[6] |=> cpu_area == CMSB_AREA_BUFFER; endproperty
	a_buf: assert property (p_buf) else $error("buffer area misdecoded");
	property p_unused; cpu_rd && inr && cpu_addr[6] && cpu_addr[3:1] == 3'h7 |=> cpu_rdata == 8'h00; endproperty
	a_unused: assert property (p_unused) else $error("unused byte not zero");
	property p_rxprio; cpu_rd && cpu_addr == 16'h014D |=> cpu_rdata == 8'h00; endproperty
	a_rxprio: assert property (p_rxprio) else $error("receive priority byte not zero");
	property p_remote; tx_valid && tx_frame.rtr |-> tx_frame.byte_count == 4'h0; endproperty
	a_remote: assert property (p_remote) else $error("remote frame carries bytes");
	property p_std; tx_valid && !tx_frame.ide |-> tx_frame.ident[17:0] == 18'h00000; endproperty
	a_std: assert property (p_std) else $error("standard ident not left aligned");
	c_wr: cover property (cpu_wr && inr && cpu_addr[6]);
	c_bg: cover property (cpu_rd && test_mode);
	c_tx: cover property (tx_valid && tx_frame.ide);
endmodule : cmsb_storage_monitor

bind cmsb_storage cmsb_storage_monitor #(.ADDR_W(ADDR_W)) u_mon (.clk(clk), .reset_n(reset_n),
	.test_mode(test_mode), .cpu_addr(cpu_addr), .cpu_rd(cpu_rd), .cpu_wr(cpu_wr), .cpu_rdata(cpu_rdata),
	.cpu_hit(cpu_hit), .cpu_area(cpu_area), .tx_valid(tx_valid), .tx_frame(tx_frame));

//--- test/cmsb_storage_tb.sv
// self-checking bench for the message buffer storage
`timescale 1ns/100ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
	$display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module cmsb_storage_tb;
	import cmsb_pkg::*;
	logic clk = 1'h0, reset_n = 1'h0, test_mode = 1'h0, cpu_rd = 1'h0, cpu_wr = 1'h0;
	logic rx_store = 1'h0, rx_copy = 1'h0, tx_arbitrate = 1'h0, cpu_hit, tx_valid;
	logic [15:0] cpu_addr = 16'h0000;
	logic [7:0] cpu_wdata = 8'h00, cpu_rdata;
	logic [2:0] tx_request = 3'h0;
	logic [1:0] tx_winner;
	cmsb_area_e cpu_area;
	cmsb_rx_s rx_frame = '0;
	cmsb_tx_s tx_frame;
	int num_errors = 0, tests_run = 0;
	logic [15:0] map_a [12] = '{16'h0100, 16'h0108, 16'h0109, 16'h010D, 16'h010E, 16'h010F, 16'h0110,
		16'h011F, 16'h013C, 16'h013D, 16'h013F, 16'h017E};
	cmsb_area_e map_r [12] = '{CMSB_AREA_CONTROL, CMSB_AREA_CONTROL, CMSB_AREA_RESERVED, CMSB_AREA_RESERVED,
		CMSB_AREA_ERRCNT, CMSB_AREA_ERRCNT, CMSB_AREA_FILTER, CMSB_AREA_FILTER, CMSB_AREA_RESERVED,
		CMSB_AREA_PORT, CMSB_AREA_PORT, CMSB_AREA_BUFFER};
	always #4 clk = ~clk;
	cmsb_storage dut (.clk(clk), .reset_n(reset_n), .test_mode(test_mode), .cpu_addr(cpu_addr), .cpu_rd(cpu_rd),
		.cpu_wr(cpu_wr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .cpu_hit(cpu_hit), .cpu_area(cpu_area),
		.rx_store(rx_store), .rx_frame(rx_frame), .rx_copy(rx_copy), .tx_request(tx_request),
		.tx_arbitrate(tx_arbitrate), .tx_valid(tx_valid), .tx_winner(tx_winner), .tx_frame(tx_frame));
	// ============================================================
	// helpers
	function automatic logic [7:0] pat(int i);
		return 8'(i * 7 + 3);
	endfunction : pat
	function automatic logic [31:0] ext_img(logic [28:0] id, logic srr, logic rtr);
		return {id[28:18], srr, 1'h1, id[17:0], rtr};
	endfunction : ext_img
	function automatic logic [31:0] std_img(logic [10:0] id, logic rtr);
		return {id, rtr, 1'h0, 19'h00000};
	endfunction : std_img
	task automatic complete_run;
		$display("checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : complete_run
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		cpu_addr = a;
		cpu_wdata = d;
		cpu_wr = 1'h1;
		@(negedge clk);
		cpu_wr = 1'h0;
		@(negedge clk);
	endtask : wr
	task automatic rd(input logic [15:0] a, input logic [7:0] e, input cmsb_area_e ar);
		cpu_addr = a;
		cpu_rd = 1'h1;
		@(negedge clk);
		cpu_rd = 1'h0;
		`CHK("hit", ar != CMSB_AREA_NONE, cpu_hit)
		`CHK("area", ar, cpu_area)
		`CHK("rdata", e, cpu_rdata)
		@(negedge clk);
	endtask : rd
	task automatic chk_id(input logic [15:0] a, input logic [31:0] img);
		for (int i = 0; i < 4; i++)
			rd(a + 16'(i), img[31-8*i -: 8], CMSB_AREA_BUFFER);
	endtask : chk_id
	task automatic ld(input logic [15:0] a, input logic [31:0] img, input logic [7:0] dl, input logic [7:0] pr);
		for (int i = 0; i < 4; i++)
			wr(a + 16'(i), img[31-8*i -: 8]);
		wr(a + 16'h000C, dl);
		wr(a + 16'h000D, pr);
	endtask : ld
	task automatic rx_load(input cmsb_rx_s f);
		rx_frame = f;
		rx_store = 1'h1;
		@(negedge clk);
		rx_store = 1'h0;
		rx_copy = 1'h1;
		@(negedge clk);
		rx_copy = 1'h0;
	endtask : rx_load
	task automatic arb(input logic [2:0] r, input logic v, input logic [1:0] w);
		tx_request = r;
		tx_arbitrate = 1'h1;
		@(negedge clk);
		tx_arbitrate = 1'h0;
		`CHK("valid", v, tx_valid)
		if (v)
			`CHK("winner", w, tx_winner)
		@(negedge clk);
	endtask : arb
	// ============================================================
	// scenarios
	task automatic s_tx_rw;
		for (int i = 0; i < 42; i++)
			wr(16'h0150 + 16'(16 * (i / 14) + i % 14), pat(i));
		for (int i = 0; i < 42; i++)
			rd(16'h0150 + 16'(16 * (i / 14) + i % 14), pat(i), CMSB_AREA_BUFFER);
	endtask : s_tx_rw
	task automatic s_rx;
		logic [31:0] e;
		e = ext_img(29'h1ABCDE57, 1'h0, 1'h1);
		rx_load({1'h1, 1'h0, 1'h1, 29'h1ABCDE57, 4'h8, 64'h0123456789ABCDEF});
		chk_id(16'h0140, e);
		for (int i = 0; i < 8; i++)
			rd(16'h0144 + 16'(i), 8'(64'h0123456789ABCDEF >> (56 - 8 * i)), CMSB_AREA_BUFFER);
		rd(16'h014C, 8'h08, CMSB_AREA_BUFFER);
		wr(16'h0140, 8'h00);
		rd(16'h0140, e[31:24], CMSB_AREA_BUFFER);
		rd(16'h014D, 8'h00, CMSB_AREA_BUFFER);
		rx_load({1'h0, 1'h0, 1'h1, 18'h00000, 11'h5A3, 4'h0, 64'h0000000000000000});
		chk_id(16'h0140, std_img(11'h5A3, 1'h1));
	endtask : s_rx
	task automatic s_bg;
		logic [31:0] e;
		e = ext_img(29'h15555555, 1'h1, 1'h0);
		test_mode = 1'h1;
		rx_load({1'h1, 1'h1, 1'h0, 29'h15555555, 4'h2, 64'h0000000000000000});
		rd(16'h0120, e[31:24], CMSB_AREA_RESERVED);
		test_mode = 1'h0;
		rd(16'h0120, 8'h00, CMSB_AREA_RESERVED);
	endtask : s_bg
	task automatic s_map;
		wr(16'h015E, 8'hFF);
		rd(16'h015E, 8'h00, CMSB_AREA_BUFFER);
		for (int i = 0; i < 12; i++)
			rd(map_a[i], 8'h00, map_r[i]);
		rd(16'h0150, pat(0), CMSB_AREA_BUFFER);
		rd(16'h0180, pat(0), CMSB_AREA_NONE);
		rd(16'h00FF, pat(0), CMSB_AREA_NONE);
	endtask : s_map
	task automatic s_arb;
		ld(16'h0150, std_img(11'h5A3, 1'h1), 8'h05, 8'h05);
		ld(16'h0160, ext_img(29'h0ABCDE57, 1'h1, 1'h0), 8'h08, 8'h03);
		wr(16'h017D, 8'h03);
		arb(3'h7, 1'h1, 2'h1);
		`CHK("ident", 29'h0ABCDE57, tx_frame.ident)
		`CHK("ide", 1'h1, tx_frame.ide)
		`CHK("count", 4'h8, tx_frame.byte_count)
		`CHK("srr", 1'h1, tx_frame.srr)
		`CHK("dlc", 4'h8, tx_frame.dlc)
		for (int i = 0; i < 8; i++)
			`CHK("payload", pat(18 + i), tx_frame.payload[63-8*i -: 8])
		arb(3'h5, 1'h1, 2'h2);
		`CHK("ide", 1'h1, tx_frame.ide)
		`CHK("clamp", 4'h8, tx_frame.byte_count)
		arb(3'h1, 1'h1, 2'h0);
		`CHK("std", {11'h5A3, 18'h00000}, tx_frame.ident)
		`CHK("rtr", 1'h1, tx_frame.rtr)
		`CHK("remote", 4'h0, tx_frame.byte_count)
		`CHK("dlc", 4'h5, tx_frame.dlc)
		arb(3'h0, 1'h0, 2'h0);
	endtask : s_arb
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		complete_run();
	end
	initial begin
		repeat (10) @(negedge clk);
		reset_n = 1'h1;
		@(negedge clk);
		`CHK("tx_valid", 1'h0, tx_valid)
		`CHK("winner", 2'h0, tx_winner)
		`CHK("rdata", CMSB_RDATA_RESET, cpu_rdata)
		`CHK("hit", 1'h0, cpu_hit)
		`CHK("area", CMSB_AREA_NONE, cpu_area)
		s_tx_rw();
		s_rx();
		s_bg();
		s_map();
		s_arb();
		complete_run();
	end
endmodule : cmsb_storage_tb
